// [cbm_pkg.sv]
// Constants, register map and state encoding for the block move and flag unit
package cbm_pkg;

  // ---------------------------------------------------------------------------
  // Bus and register map
  // ---------------------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0]  OFS_CTRL  = 8'h00;
  localparam logic [7:0]  OFS_STAT  = 8'h04;
  localparam logic [7:0]  OFS_SRC   = 8'h08;
  localparam logic [7:0]  OFS_DST   = 8'h0C;
  localparam logic [7:0]  OFS_CNT   = 8'h10;
  localparam logic [7:0]  OFS_OPA   = 8'h14;
  localparam logic [7:0]  OFS_OPB   = 8'h18;
  localparam logic [7:0]  OFS_FOP   = 8'h1C;
  localparam logic [7:0]  OFS_FLAGS = 8'h20;
  localparam logic [7:0]  OFS_RES   = 8'h24;
  localparam logic [7:0]  OFS_COST  = 8'h28;

  // Field positions
  localparam int unsigned CTRL_START_B = 0;
  localparam int unsigned CTRL_START_W = 1;
  localparam int unsigned CTRL_EXR     = 2;
  localparam int unsigned STAT_BUSY    = 0;
  localparam int unsigned STAT_DONE    = 1;
  localparam int unsigned STAT_CYC_LSB = 8;
  localparam int unsigned FLG_H        = 0;
  localparam int unsigned FLG_Z        = 1;
  localparam int unsigned FLG_N        = 2;
  localparam int unsigned FLG_QN       = 3;
  localparam int unsigned COST_BM_LSB  = 8;
  localparam int unsigned H_BIT_W      = 11;
  localparam int unsigned H_BIT_L      = 27;

  // Flag operation codes
  localparam logic [2:0] FOP_ADD_W  = 3'h0;
  localparam logic [2:0] FOP_SUB_W  = 3'h1;
  localparam logic [2:0] FOP_ADD_L  = 3'h2;
  localparam logic [2:0] FOP_SUB_L  = 3'h3;
  localparam logic [2:0] FOP_ADDX_W = 3'h4;
  localparam logic [2:0] FOP_DIVXS  = 3'h5;
  localparam logic [2:0] FOP_DIVXU  = 3'h6;

  // ---------------------------------------------------------------------------
  // State counts and reset values
  // ---------------------------------------------------------------------------
  localparam logic [23:0] BM_OVH_STATES  = 24'h000004;
  localparam logic [23:0] BM_BYTE_STATES = 24'h000002;
  localparam logic [23:0] EXR_EXTRA      = 24'h000001;
  localparam logic [7:0]  MREG_BASE      = 8'h03;
  localparam logic [7:0]  MREG_PER       = 8'h02;
  localparam logic [2:0]  MREG_MIN       = 3'h2;
  localparam logic [2:0]  MREG_MAX       = 3'h4;
  localparam logic [31:0] RST_WORD       = 32'h00000000;
  localparam logic [15:0] CNT_STEP       = 16'h0001;
  localparam logic [31:0] PTR_STEP       = 32'h00000001;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_OVH  = 4'b0010,
    ST_RD   = 4'b0100,
    ST_WR   = 4'b1000
  } cbm_state_t;

endpackage : cbm_pkg

// [cbm_exec.sv]
// Block move engine with flag evaluation unit, reached over APB
`timescale 1ns/1ps
`default_nettype none
module cbm_exec (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // On-chip memory, one byte per step
  output logic      [31:0] mem_addr_o,
  output logic             mem_rd_o,
  output logic             mem_wr_o,
  output logic      [7:0]  mem_wdata_o,
  input  wire logic [7:0]  mem_rdata_i,
  // Status
  output logic             busy_o,
  output logic             done_o
);

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  cbm_pkg::cbm_state_t st_q;
  logic [31:0] src_q, dst_q, opa_q, opb_q, res_q;
  logic [15:0] cnt_q;
  logic        word_mode_q, exr_q, done_q;
  logic [3:0]  flags_q;
  logic [2:0]  nregs_q;
  logic [23:0] ovh_q, cyc_q, exp_q;

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  wire setup_w = psel_i & ~penable_i;
  wire wr_w    = psel_i & penable_i & pwrite_i;
  wire busy_w  = (st_q != cbm_pkg::ST_IDLE);
  // Pointer and count writes ignored mid-transfer to keep the loop coherent
  wire cfg_ok  = wr_w & ~busy_w;
  wire wr_ctrl = wr_w & (paddr_i == cbm_pkg::OFS_CTRL);
  wire wr_src  = cfg_ok & (paddr_i == cbm_pkg::OFS_SRC);
  wire wr_dst  = cfg_ok & (paddr_i == cbm_pkg::OFS_DST);
  wire wr_cnt  = cfg_ok & (paddr_i == cbm_pkg::OFS_CNT);
  wire wr_opa  = wr_w & (paddr_i == cbm_pkg::OFS_OPA);
  wire wr_opb  = wr_w & (paddr_i == cbm_pkg::OFS_OPB);
  wire fop_go  = cfg_ok & (paddr_i == cbm_pkg::OFS_FOP);
  wire wr_cost = wr_w & (paddr_i == cbm_pkg::OFS_COST);
  wire start_b = wr_ctrl & ~busy_w & pwdata_i[cbm_pkg::CTRL_START_B];
  wire start_w = wr_ctrl & ~busy_w & pwdata_i[cbm_pkg::CTRL_START_W] & ~start_b;
  wire start   = start_b | start_w;
  // EXTENDED_CONTROL_REG bit written with the start bit already counts for that move
  wire exr_now = wr_ctrl ? pwdata_i[cbm_pkg::CTRL_EXR] : exr_q;

  // ---------------------------------------------------------------------------
  // Cost figures
  // ---------------------------------------------------------------------------
  wire [23:0] exr_add  = exr_q ? cbm_pkg::EXR_EXTRA : 24'h000000;
  wire [23:0] ovh_full = cbm_pkg::BM_OVH_STATES + (exr_now ? cbm_pkg::EXR_EXTRA : 24'h000000);
  wire [23:0] n_byte   = {16'h0000, cnt_q[7:0]};
  wire [23:0] n_word   = {8'h00, cnt_q};
  wire [23:0] exp_b    = ovh_full + 24'(n_byte * cbm_pkg::BM_BYTE_STATES);
  wire [23:0] exp_w    = ovh_full + 24'(n_word * cbm_pkg::BM_BYTE_STATES);
  wire        nreg_ok  = (nregs_q >= cbm_pkg::MREG_MIN) && (nregs_q <= cbm_pkg::MREG_MAX);
  wire [7:0]  mreg_st  = nreg_ok ? 8'(cbm_pkg::MREG_BASE + 8'(nregs_q) * cbm_pkg::MREG_PER
                                      + exr_add[7:0]) : 8'h00;
  // Loop governed by the low byte or the full word
  wire        cnt_zero = word_mode_q ? (cnt_q == 16'h0000) : (cnt_q[7:0] == 8'h00);
  wire        cnt_last = word_mode_q ? (cnt_q == cbm_pkg::CNT_STEP)
                                     : (cnt_q[7:0] == cbm_pkg::CNT_STEP[7:0]);

  // ---------------------------------------------------------------------------
  // Flag evaluation
  // ---------------------------------------------------------------------------
  wire [2:0]  fop     = pwdata_i[2:0];
  wire [12:0] hw_sum  = {1'b0, opa_q[cbm_pkg::H_BIT_W:0]} + {1'b0, opb_q[cbm_pkg::H_BIT_W:0]};
  wire [28:0] hl_sum  = {1'b0, opa_q[cbm_pkg::H_BIT_L:0]} + {1'b0, opb_q[cbm_pkg::H_BIT_L:0]};
  wire        h_addw  = hw_sum[cbm_pkg::H_BIT_W+1];
  wire        h_subw  = opa_q[cbm_pkg::H_BIT_W:0] < opb_q[cbm_pkg::H_BIT_W:0];
  wire        h_addl  = hl_sum[cbm_pkg::H_BIT_L+1];
  wire        h_subl  = opa_q[cbm_pkg::H_BIT_L:0] < opb_q[cbm_pkg::H_BIT_L:0];
  wire [15:0] sum_w   = opa_q[15:0] + opb_q[15:0];
  wire [15:0] dif_w   = opa_q[15:0] - opb_q[15:0];
  wire [31:0] sum_l   = opa_q + opb_q;
  wire [31:0] dif_l   = opa_q - opb_q;
  wire        dvs_neg = opb_q[15];
  wire        dvs_z   = (opb_q[15:0] == 16'h0000);
  wire [15:0] mag_a   = opa_q[15] ? 16'(-opa_q[15:0]) : opa_q[15:0];
  wire [15:0] mag_b   = opb_q[15] ? 16'(-opb_q[15:0]) : opb_q[15:0];
  // Sign only: no divider needed, a quotient of zero is not negative
  wire        q_neg   = (opa_q[15] ^ opb_q[15]) & ~dvs_z & (mag_a >= mag_b);
  logic [3:0]  flags_d;
  logic [31:0] res_d;

  always_comb begin
    flags_d = flags_q;
    res_d   = res_q;
    case (fop)
      cbm_pkg::FOP_ADD_W: begin
        flags_d[cbm_pkg::FLG_H] = h_addw;
        flags_d[cbm_pkg::FLG_Z] = (sum_w == 16'h0000);
        flags_d[cbm_pkg::FLG_N] = sum_w[15];
        res_d = {16'h0000, sum_w};
      end
      cbm_pkg::FOP_SUB_W: begin
        flags_d[cbm_pkg::FLG_H] = h_subw;
        flags_d[cbm_pkg::FLG_Z] = (dif_w == 16'h0000);
        flags_d[cbm_pkg::FLG_N] = dif_w[15];
        res_d = {16'h0000, dif_w};
      end
      cbm_pkg::FOP_ADD_L: begin
        flags_d[cbm_pkg::FLG_H] = h_addl;
        flags_d[cbm_pkg::FLG_Z] = (sum_l == cbm_pkg::RST_WORD);
        flags_d[cbm_pkg::FLG_N] = sum_l[31];
        res_d = sum_l;
      end
      cbm_pkg::FOP_SUB_L: begin
        flags_d[cbm_pkg::FLG_H] = h_subl;
        flags_d[cbm_pkg::FLG_Z] = (dif_l == cbm_pkg::RST_WORD);
        flags_d[cbm_pkg::FLG_N] = dif_l[31];
        res_d = dif_l;
      end
      cbm_pkg::FOP_ADDX_W: begin
        flags_d[cbm_pkg::FLG_H] = h_addw;
        flags_d[cbm_pkg::FLG_Z] = (sum_w == 16'h0000) & flags_q[cbm_pkg::FLG_Z];
        flags_d[cbm_pkg::FLG_N] = sum_w[15];
        res_d = {16'h0000, sum_w};
      end
      cbm_pkg::FOP_DIVXS: begin
        flags_d[cbm_pkg::FLG_N]  = dvs_neg;
        flags_d[cbm_pkg::FLG_Z]  = dvs_z;
        flags_d[cbm_pkg::FLG_QN] = q_neg;
      end
      cbm_pkg::FOP_DIVXU: begin
        flags_d[cbm_pkg::FLG_Z]  = dvs_z;
      end
      default: begin
        flags_d = flags_q;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------------------
  logic [31:0] rd_mux;
  logic        rd_hit;

  always_comb begin
    rd_mux = cbm_pkg::RST_WORD;
    rd_hit = 1'b1;
    case (paddr_i)
      cbm_pkg::OFS_CTRL:  rd_mux[cbm_pkg::CTRL_EXR] = exr_q;
      cbm_pkg::OFS_STAT:  rd_mux = {cyc_q, 6'h00, done_q, busy_w};
      cbm_pkg::OFS_SRC:   rd_mux = src_q;
      cbm_pkg::OFS_DST:   rd_mux = dst_q;
      cbm_pkg::OFS_CNT:   rd_mux = {16'h0000, cnt_q};
      cbm_pkg::OFS_OPA:   rd_mux = opa_q;
      cbm_pkg::OFS_OPB:   rd_mux = opb_q;
      cbm_pkg::OFS_FOP:   rd_mux = cbm_pkg::RST_WORD;
      cbm_pkg::OFS_FLAGS: rd_mux = {28'h0000000, flags_q};
      cbm_pkg::OFS_RES:   rd_mux = res_q;
      cbm_pkg::OFS_COST:  rd_mux = {exp_w, mreg_st};
      default:            rd_hit = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------------------
  // APB answer: data latched at setup, zero wait states
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prdata_o  <= cbm_pkg::RST_WORD;
      pslverr_o <= 1'b0;
      pready_o  <= 1'b0;
    end else begin
      pready_o <= 1'b1;
      if (setup_w) begin
        prdata_o  <= pwrite_i ? cbm_pkg::RST_WORD : rd_mux;
        pslverr_o <= ~rd_hit;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      opa_q   <= cbm_pkg::RST_WORD;
      opb_q   <= cbm_pkg::RST_WORD;
      res_q   <= cbm_pkg::RST_WORD;
      flags_q <= 4'h0;
      exr_q   <= 1'b0;
      nregs_q <= 3'h0;
    end else begin
      if (wr_opa) opa_q <= pwdata_i;
      if (wr_opb) opb_q <= pwdata_i;
      if (wr_ctrl) exr_q <= pwdata_i[cbm_pkg::CTRL_EXR];
      if (wr_cost) nregs_q <= pwdata_i[2:0];
      // Flags move only on a flag command, never during a block move
      if (fop_go) begin
        flags_q <= flags_d;
        res_q   <= res_d;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Block move sequencer
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q        <= cbm_pkg::ST_IDLE;
      src_q       <= cbm_pkg::RST_WORD;
      dst_q       <= cbm_pkg::RST_WORD;
      cnt_q       <= 16'h0000;
      word_mode_q <= 1'b0;
      ovh_q       <= 24'h000000;
      cyc_q       <= 24'h000000;
      exp_q       <= 24'h000000;
      done_q      <= 1'b0;
      mem_addr_o  <= cbm_pkg::RST_WORD;
      mem_rd_o    <= 1'b0;
      mem_wr_o    <= 1'b0;
      mem_wdata_o <= 8'h00;
    end else begin
      done_q <= 1'b0;
      if (wr_src) src_q <= pwdata_i;
      if (wr_dst) dst_q <= pwdata_i;
      if (wr_cnt) cnt_q <= pwdata_i[15:0];
      if (busy_w) cyc_q <= cyc_q + cbm_pkg::EXR_EXTRA;
      case (st_q)
        cbm_pkg::ST_IDLE: begin
          if (start) begin
            st_q        <= cbm_pkg::ST_OVH;
            word_mode_q <= start_w;
            ovh_q       <= ovh_full - cbm_pkg::EXR_EXTRA;
            exp_q       <= start_w ? exp_w : exp_b;
            cyc_q       <= 24'h000000;
          end
        end
        cbm_pkg::ST_OVH: begin
          ovh_q <= ovh_q - cbm_pkg::EXR_EXTRA;
          if (ovh_q == 24'h000000) begin
            if (cnt_zero) begin
              st_q   <= cbm_pkg::ST_IDLE;
              done_q <= 1'b1;
            end else begin
              st_q       <= cbm_pkg::ST_RD;
              mem_rd_o   <= 1'b1;
              mem_addr_o <= src_q;
            end
          end
        end
        cbm_pkg::ST_RD: begin
          // Read data valid in the read cycle: single-cycle on-chip memory
          st_q        <= cbm_pkg::ST_WR;
          mem_rd_o    <= 1'b0;
          mem_wr_o    <= 1'b1;
          mem_addr_o  <= dst_q;
          mem_wdata_o <= mem_rdata_i;
          src_q       <= src_q + cbm_pkg::PTR_STEP;
        end
        cbm_pkg::ST_WR: begin
          mem_wr_o <= 1'b0;
          dst_q    <= dst_q + cbm_pkg::PTR_STEP;
          if (word_mode_q) cnt_q <= cnt_q - cbm_pkg::CNT_STEP;
          else cnt_q[7:0] <= cnt_q[7:0] - cbm_pkg::CNT_STEP[7:0];
          if (cnt_last) begin
            st_q   <= cbm_pkg::ST_IDLE;
            done_q <= 1'b1;
          end else begin
            st_q       <= cbm_pkg::ST_RD;
            mem_rd_o   <= 1'b1;
            mem_addr_o <= src_q;
          end
        end
        default: begin
          st_q <= cbm_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      busy_o <= start | (busy_w & ~(st_q == cbm_pkg::ST_IDLE));
      done_o <= 1'b0;
      if ((st_q == cbm_pkg::ST_WR && cnt_last) || (st_q == cbm_pkg::ST_OVH && ovh_q == 24'h000000
          && cnt_zero)) begin
        busy_o <= 1'b0;
        done_o <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  property p_bm_cost;
    done_q |-> (cyc_q == exp_q);
  endproperty
  a_bm_cost: assert property (p_bm_cost) else $error("block move state count wrong");

  property p_exr_cost;
    (start && pwdata_i[cbm_pkg::CTRL_EXR]) |=> (ovh_q == cbm_pkg::BM_OVH_STATES);
  endproperty
  a_exr_cost: assert property (p_exr_cost) else $error("extra state missing");

  property p_zero_count;
    (st_q == cbm_pkg::ST_OVH && ovh_q == 24'h000000 && cnt_zero) |=> !mem_rd_o && done_q;
  endproperty
  a_zero_count: assert property (p_zero_count) else $error("zero count moved data");

  property p_copy;
    mem_rd_o |=> mem_wr_o && (mem_wdata_o == $past(mem_rdata_i)) && (src_q == $past(src_q) + 32'h1);
  endproperty
  a_copy: assert property (p_copy) else $error("byte copy or source step wrong");

  property p_byte_hi;
    (busy_w && !word_mode_q) |=> $stable(cnt_q[15:8]);
  endproperty
  a_byte_hi: assert property (p_byte_hi) else $error("byte form touched high count");

  property p_word_dec;
    (mem_wr_o && word_mode_q) |=> (cnt_q == $past(cnt_q) - 16'h1);
  endproperty
  a_word_dec: assert property (p_word_dec) else $error("word count not stepped");

  property p_end_state;
    done_q |-> cnt_zero;
  endproperty
  a_end_state: assert property (p_end_state) else $error("count not zero at end");

  property p_flags_hold;
    busy_w |=> $stable(flags_q);
  endproperty
  a_flags_hold: assert property (p_flags_hold) else $error("flags changed by move");

  property p_mreg;
    (nregs_q == cbm_pkg::MREG_MIN && !exr_q) |-> (mreg_st == 8'h07);
  endproperty
  a_mreg: assert property (p_mreg) else $error("save/restore cost wrong");

  property p_keep_z;
    (fop_go && fop == cbm_pkg::FOP_ADDX_W && sum_w == 16'h0000) |=> $stable(flags_q[cbm_pkg::FLG_Z]);
  endproperty
  a_keep_z: assert property (p_keep_z) else $error("zero result changed flag");

  property p_div;
    (fop_go && fop == cbm_pkg::FOP_DIVXS) |=>
      (flags_q[cbm_pkg::FLG_N] == opb_q[15]) && (flags_q[cbm_pkg::FLG_Z] == (opb_q[15:0] == 16'h0));
  endproperty
  a_div: assert property (p_div) else $error("divide flags wrong");

endmodule : cbm_exec
`default_nettype wire

// [cbm_mem_model.sv]
// Byte-wide on-chip memory model facing the move engine
`timescale 1ns/1ps
`default_nettype none
module cbm_mem_model (
  // Clock
  input  wire logic        clk_sys_i,
  // Byte port
  input  wire logic [31:0] mem_addr_i,
  input  wire logic        mem_rd_i,
  input  wire logic        mem_wr_i,
  input  wire logic [7:0]  mem_wdata_i,
  output logic      [7:0]  mem_rdata_o
);
  // ----------------------------
  // Storage
  // ----------------------------
  logic [7:0] mem [256];
  logic [7:0] last_q = 8'h00;

  initial for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h5A;

  // Single-cycle read, no wait states
  // Unselected: inverse of last byte, so a late sample never matches
  assign mem_rdata_o = mem_rd_i ? mem[mem_addr_i[7:0]] : ~last_q;

  always @(posedge clk_sys_i) begin
    if (mem_rd_i) last_q <= mem[mem_addr_i[7:0]];
    if (mem_wr_i) mem[mem_addr_i[7:0]] <= mem_wdata_i;
  end
endmodule : cbm_mem_model
`default_nettype wire

// [cbm_exec_bench.sv]
// Self-checking bench for the block move and flag engine
`timescale 1ns/1ps
`default_nettype none
module cbm_exec_bench;
  // ----------------------------
  // Signals
  // ----------------------------
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic        clk_sys_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        psel_i    = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i  = 1'b0;
  logic [7:0]  paddr_i   = 8'h00;
  logic [31:0] pwdata_i  = 32'h00000000;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic [31:0] mem_addr_o;
  logic        mem_rd_o;
  logic        mem_wr_o;
  logic [7:0]  mem_wdata_o;
  logic [7:0]  mem_rdata_i;
  logic        busy_o;
  logic        done_o;
  logic [32:0] exp_q[$];
  logic [32:0] msk_q[$];
  logic [31:0] a, b, f;
  logic [32:0] m;
  int          num_errors = 0;
  int          tests_run  = 0;
  int          rd_cnt     = 0;
  int          seed       = 32'h4157;

  initial begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  cbm_exec dut_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
    .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i), .busy_o(busy_o), .done_o(done_o));

  cbm_mem_model mem_u (.clk_sys_i(clk_sys_i), .mem_addr_i(mem_addr_o), .mem_rd_i(mem_rd_o),
    .mem_wr_i(mem_wr_o), .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));

  // ----------------------------
  // Tasks
  // ----------------------------
  task automatic chk(input string what, input logic [32:0] e, input logic [32:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic conclude;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge clk_sys_i);
    psel_i   <= 1'b1;
    pwrite_i <= wr;
    paddr_i  <= ad;
    pwdata_i <= wd;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    @(posedge clk_sys_i);
    while (pready_o !== 1'b1) @(posedge clk_sys_i);
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] mk);
    exp_q.push_back({1'b0, e & mk});
    msk_q.push_back({1'b1, mk});
    apb(1'b0, ad, 32'h00000000);
  endtask : rd

  task automatic move(input logic [31:0] ctl, input int cyc, input int acc);
    int k;
    k = 0;
    rd_cnt = 0;
    apb(1'b1, cbm_pkg::OFS_CTRL, ctl);
    do begin
      @(posedge clk_sys_i);
      #1;
      k++;
      if (k == 1) chk("busy", 33'h1, 33'(busy_o));
    end while (done_o !== 1'b1 && k < 600);
    chk("busy end", 33'h0, 33'(busy_o));
    chk("move cycles", 33'(cyc), 33'(k));
    chk("byte reads", 33'(acc), 33'(rd_cnt));
  endtask : move

  // Reads are noted when issued and compared when they complete
  always @(posedge clk_sys_i) begin
    if (mem_rd_o === 1'b1) rd_cnt++;
    if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i) begin
      m = msk_q.pop_front();
      chk("read", exp_q.pop_front(), {pslverr_o, prdata_o} & m);
    end
  end

  // ----------------------------
  // Sequence
  // ----------------------------
  initial begin
    repeat (5) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    rd(cbm_pkg::OFS_STAT, 32'h00000000, ALL);
    exp_q.push_back({1'b1, 32'h00000000});
    msk_q.push_back({1'b1, ALL});
    apb(1'b0, 8'h2C, 32'h00000000);
    for (int r = 0; r < 4; r++) begin
      for (int op = 0; op < 7; op++) begin
        a = $random(seed);
        b = $random(seed);
        if (op > 4) begin
          a[14:13] = 2'b01;
          b[15:0] = b[15] ? {12'hFFF, b[3:0]} : {12'h000, b[3:0] | 4'h1};
        end
        if (op != 4) begin
          apb(1'b1, cbm_pkg::OFS_OPA, a);
          apb(1'b1, cbm_pkg::OFS_OPB, b);
          apb(1'b1, cbm_pkg::OFS_FOP, 32'(op));
          case (op)
            0: f = 32'(13'(a[11:0]) + 13'(b[11:0])) >> 12;
            1: f = 32'(a[11:0] < b[11:0]);
            2: f = 32'(29'(a[27:0]) + 29'(b[27:0])) >> 28;
            3: f = 32'(a[27:0] < b[27:0]);
            5: f = {28'h0, a[15] ^ b[15], b[15], 2'b00};
            // Unsigned divide touches only Z: N and QN stay from the signed one
            6: f = f & 32'h0000000C;
            default: f = 32'h00000000;
          endcase
          rd(cbm_pkg::OFS_FLAGS, f, op > 4 ? 32'hE : 32'h1);
        end
      end
    end
    apb(1'b1, cbm_pkg::OFS_OPA, 32'h00000000);
    apb(1'b1, cbm_pkg::OFS_OPB, 32'h00000000);
    apb(1'b1, cbm_pkg::OFS_FOP, 32'(cbm_pkg::FOP_DIVXU));
    rd(cbm_pkg::OFS_FLAGS, 32'h2, 32'h2);
    apb(1'b1, cbm_pkg::OFS_FOP, 32'(cbm_pkg::FOP_ADDX_W));
    rd(cbm_pkg::OFS_FLAGS, 32'h2, 32'h2);
    apb(1'b1, cbm_pkg::OFS_SRC, 32'h10);
    apb(1'b1, cbm_pkg::OFS_DST, 32'h80);
    apb(1'b1, cbm_pkg::OFS_CNT, 32'h1203);
    move(32'h1, 10, 3);
    rd(cbm_pkg::OFS_SRC, 32'h13, ALL);
    rd(cbm_pkg::OFS_DST, 32'h83, ALL);
    rd(cbm_pkg::OFS_CNT, 32'h1200, ALL);
    rd(cbm_pkg::OFS_FLAGS, 32'h2, 32'h2);
    for (int i = 0; i < 4; i++) begin
      chk("mem", 33'(i < 3 ? (8'h10 + i[7:0]) ^ 8'h5A : 8'h83 ^ 8'h5A), 33'(mem_u.mem[8'h80 + i]));
    end
    move(32'h1, 4, 0);
    rd(cbm_pkg::OFS_CNT, 32'h1200, ALL);
    apb(1'b1, cbm_pkg::OFS_OPA, 32'h1);
    apb(1'b1, cbm_pkg::OFS_FOP, 32'(cbm_pkg::FOP_ADDX_W));
    rd(cbm_pkg::OFS_FLAGS, 32'h0, 32'h2);
    apb(1'b1, cbm_pkg::OFS_SRC, 32'h0);
    apb(1'b1, cbm_pkg::OFS_DST, 32'h0);
    apb(1'b1, cbm_pkg::OFS_CNT, 32'h0100);
    move(32'h6, 517, 256);
    rd(cbm_pkg::OFS_SRC, 32'h100, ALL);
    rd(cbm_pkg::OFS_CNT, 32'h0, ALL);
    move(32'h6, 5, 0);
    // Software side keeps to legal register sets only
    for (int n = 2; n < 5; n++) begin
      apb(1'b1, cbm_pkg::OFS_COST, 32'(n));
      rd(cbm_pkg::OFS_COST, 32'(2 * n + 4) | 32'h500, ALL);
    end
    apb(1'b1, cbm_pkg::OFS_CTRL, 32'h0);
    apb(1'b1, cbm_pkg::OFS_CNT, 32'h5);
    apb(1'b1, cbm_pkg::OFS_COST, 32'h3);
    rd(cbm_pkg::OFS_COST, 32'h0E09, ALL);
    conclude();
  end

  // Whole run is about 950 cycles
  initial begin
    repeat (8000) @(posedge clk_sys_i);
    num_errors++;
    conclude();
  end
endmodule : cbm_exec_bench
`default_nettype wire
